// file: rtl/usb_status_power.sv
// usb device status, wake and power control registers
// assumes engine events are same-clock pulses; data line pins are async
`timescale 1ns/100ps
module usb_status_power #(
    parameter int IDLE_CYC = usb_ctl_pkg::IDLE_CYCLES,
    parameter int WAKE_CYC = usb_ctl_pkg::WAKE_CYCLES
) (
    // clock, reset, enable
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_ce,
    // register port
    input  wire usb_ctl_pkg::bus_req_s i_bus,
    output logic [7:0]                 o_rdata,
    // engine events
    input  wire logic                  i_bus_active,
    input  wire logic                  i_resume_det,
    input  wire logic                  i_reset_det,
    input  wire logic                  i_se0_noise,
    input  wire logic                  i_se1_noise,
    input  wire logic [3:0]            i_ep_hit,
    // processor side
    input  wire logic                  i_usb_irq_en,
    input  wire logic                  i_stack_full,
    output logic                       o_usb_irq,
    output logic                       o_cpu_reset,
    // data line pins
    input  wire logic                  i_dp_pin,
    input  wire logic                  i_dm_pin,
    output usb_ctl_pkg::pin_drive_s    o_pins,
    // power and mode controls, endpoint sizes
    output logic                       o_pullup_en,
    output logic                       o_pll_off,
    output logic                       o_reg33_en,
    output logic                       o_legacy_mode,
    output logic                       o_link_clk_en,
    output logic                       o_deep_idle,
    output logic [23:0]                o_ep_size
);

    // ========================================
    // helpers
    function automatic logic hit(input usb_ctl_pkg::bus_req_s r,
                                 input logic [2:0] off);
        hit = r.wr && (r.addr == off);
    endfunction

    function automatic logic [7:0] ep_bytes(input logic [1:0] code);
        ep_bytes = usb_ctl_pkg::EPX_MIN << code;
    endfunction

    // ========================================
    // state
    usb_ctl_pkg::link_state_e state_ff, nxt_state;
    logic [usb_ctl_pkg::CNT_W-1:0] idle_cnt_ff;
    logic [usb_ctl_pkg::CNT_W-1:0] wake_cnt_ff;
    logic       wake_ff;
    logic       resume_ff;
    logic       brst_ff;
    logic       rst_det_ff;
    logic       se0_ff;
    logic       se1_ff;
    logic [3:0] ep_en_ff;
    logic [3:0] ep_req_ff;
    logic [7:0] bus_ctl_ff;
    logic       pullup_ff;
    logic       dp_drv_ff;
    logic       dm_drv_ff;
    logic       lclk_ff;
    logic       deep_ff;
    logic [5:0] fifo_ff;
    logic [1:0] dp_sync_ff;
    logic [1:0] dm_sync_ff;
    logic [7:0] rdata_ff;
    logic       irq_ff;
    logic       cpu_rst_ff;
    usb_ctl_pkg::pin_drive_s pins_ff, nxt_pins;

    logic       clk_run;
    logic       idle_done;
    logic       bus_idle_flag_set;
    logic       resume_set;
    logic       brst_set;
    logic [3:0] ep_set;
    logic       ep_irq;
    logic       fifo_ovr;
    logic       wr_line;
    logic       wr_bus;
    logic       wr_epreq;

    assign clk_run   = lclk_ff && !deep_ff;
    assign idle_done = idle_cnt_ff ==
                       usb_ctl_pkg::CNT_W'(IDLE_CYC - 1);
    assign wr_line   = hit(i_bus, usb_ctl_pkg::OFF_LINE);
    assign wr_bus    = hit(i_bus, usb_ctl_pkg::OFF_BUS);
    assign wr_epreq  = hit(i_bus, usb_ctl_pkg::OFF_EPREQ);

    // ========================================
    // link state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            usb_ctl_pkg::LINK_ACTIVE: begin
                if (clk_run && idle_done) begin
                    nxt_state = usb_ctl_pkg::LINK_BUS_IDLE_FLAG;
                end
            end
            usb_ctl_pkg::LINK_BUS_IDLE_FLAG: begin
                if (i_resume_det) begin
                    nxt_state = usb_ctl_pkg::LINK_RESUME;
                end else if (i_bus_active || i_reset_det) begin
                    nxt_state = usb_ctl_pkg::LINK_ACTIVE;
                end
            end
            usb_ctl_pkg::LINK_RESUME: begin
                if (i_bus_active || i_reset_det) begin
                    nxt_state = usb_ctl_pkg::LINK_ACTIVE;
                end
            end
            default: nxt_state = usb_ctl_pkg::LINK_ACTIVE;
        endcase
    end

    assign bus_idle_flag_set   = (state_ff == usb_ctl_pkg::LINK_ACTIVE) &&
                        (nxt_state == usb_ctl_pkg::LINK_BUS_IDLE_FLAG);
    assign resume_set = (state_ff == usb_ctl_pkg::LINK_BUS_IDLE_FLAG) &&
                        (nxt_state == usb_ctl_pkg::LINK_RESUME);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= usb_ctl_pkg::LINK_ACTIVE;
        end else if (i_ce) begin
            state_ff <= nxt_state;
        end
    end

    // silence counter, restarted by bus activity but not by a detected bus reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            idle_cnt_ff <= '0;
        end else if (i_ce) begin
            if (i_bus_active || !clk_run || idle_done ||
                state_ff != usb_ctl_pkg::LINK_ACTIVE) begin
                idle_cnt_ff <= '0;
            end else begin
                idle_cnt_ff <= idle_cnt_ff + 1'b1;
            end
        end
    end

    // resume flag follows idle flag down, a set wins
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            resume_ff <= 1'b0;
        end else if (i_ce) begin
            if (resume_set) begin
                resume_ff <= 1'b1;
            end else if (nxt_state == usb_ctl_pkg::LINK_ACTIVE) begin
                resume_ff <= 1'b0;
            end
        end
    end

    // ========================================
    // remote wake pulse
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wake_ff     <= 1'b0;
            wake_cnt_ff <= '0;
        end else if (i_ce) begin
            if (!wake_ff && wr_bus && i_bus.wdata[usb_ctl_pkg::B_WAKE]) begin
                wake_ff     <= 1'b1;
                wake_cnt_ff <= '0;
            end else if (wake_ff) begin
                if (wake_cnt_ff == usb_ctl_pkg::CNT_W'(WAKE_CYC - 1)) begin
                    wake_ff <= 1'b0;
                end
                wake_cnt_ff <= wake_cnt_ff + 1'b1;
            end
        end
    end

    // ========================================
    // bus reset flag and processor reset
    assign brst_set = i_reset_det && !rst_det_ff;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_det_ff <= 1'b0;
            brst_ff    <= 1'b0;
            cpu_rst_ff <= 1'b0;
        end else if (i_ce) begin
            rst_det_ff <= i_reset_det;
            if (brst_set) begin
                brst_ff <= 1'b1;
            end else if (wr_bus && !i_bus.wdata[usb_ctl_pkg::B_BRST]) begin
                brst_ff <= 1'b0;
            end
            cpu_rst_ff <= brst_set &&
                          bus_ctl_ff[usb_ctl_pkg::B_RSTPROP];
        end
    end

    // ========================================
    // control bits of the bus register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bus_ctl_ff <= usb_ctl_pkg::BUS_RESET;
        end else if (i_ce && wr_bus) begin
            bus_ctl_ff <= i_bus.wdata;
        end
    end

    // ========================================
    // line status: pull-up, noise, ps2 drive
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pullup_ff <= 1'b0;
            dp_drv_ff <= 1'b1;
            dm_drv_ff <= 1'b1;
            se0_ff    <= 1'b0;
            se1_ff    <= 1'b0;
        end else if (i_ce) begin
            if (wr_line) begin
                pullup_ff <= i_bus.wdata[usb_ctl_pkg::B_PULLUP];
                dp_drv_ff <= i_bus.wdata[usb_ctl_pkg::B_DP_DRV];
                dm_drv_ff <= i_bus.wdata[usb_ctl_pkg::B_DM_DRV];
            end
            if (clk_run && i_se0_noise) begin
                se0_ff <= 1'b1;
            end else if (wr_line && !i_bus.wdata[usb_ctl_pkg::B_SE0]) begin
                se0_ff <= 1'b0;
            end
            if (clk_run && i_se1_noise) begin
                se1_ff <= 1'b1;
            end else if (wr_line && !i_bus.wdata[usb_ctl_pkg::B_SE1]) begin
                se1_ff <= 1'b0;
            end
        end
    end

    // pin levels from outside the clock domain
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dp_sync_ff <= 2'h0;
            dm_sync_ff <= 2'h0;
        end else if (i_ce) begin
            dp_sync_ff <= {dp_sync_ff[0], i_dp_pin};
            dm_sync_ff <= {dm_sync_ff[0], i_dm_pin};
        end
    end

    // wake drives a k state; ps2 mode is open drain
    always_comb begin
        nxt_pins = '0;
        if (wake_ff) begin
            nxt_pins.dp_out = 1'b0;
            nxt_pins.dp_oe  = 1'b1;
            nxt_pins.dm_out = 1'b1;
            nxt_pins.dm_oe  = 1'b1;
        end else if (bus_ctl_ff[usb_ctl_pkg::B_LEGACY]) begin
            nxt_pins.dp_oe = !dp_drv_ff;
            nxt_pins.dm_oe = !dm_drv_ff;
        end
    end

    // ========================================
    // endpoints
    assign ep_set = clk_run ? i_ep_hit : 4'h0;
    assign ep_irq = |(ep_set & ep_en_ff) && i_usb_irq_en && !i_stack_full;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ep_en_ff  <= 4'h0;
            ep_req_ff <= 4'h0;
        end else if (i_ce) begin
            if (hit(i_bus, usb_ctl_pkg::OFF_EPEN)) begin
                ep_en_ff <= i_bus.wdata[3:0];
            end
            if (wr_epreq) begin
                ep_req_ff <= (ep_req_ff & i_bus.wdata[3:0]) | ep_set;
            end else begin
                ep_req_ff <= ep_req_ff | ep_set;
            end
        end
    end

    // endpoint 0 fixed, 1 to 3 share the budget
    assign fifo_ovr = (10'(ep_bytes(fifo_ff[1:0])) +
                       10'(ep_bytes(fifo_ff[3:2])) +
                       10'(ep_bytes(fifo_ff[5:4]))) >
                      10'(usb_ctl_pkg::EPX_BUDGET);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fifo_ff <= usb_ctl_pkg::FIFO_RESET;
            o_ep_size <= {usb_ctl_pkg::EPX_MIN, usb_ctl_pkg::EPX_MIN,
                          usb_ctl_pkg::EPX_MIN};
        end else if (i_ce) begin
            if (hit(i_bus, usb_ctl_pkg::OFF_FIFO) && !i_bus.wr) begin
                fifo_ff <= fifo_ff;
            end else if (hit(i_bus, usb_ctl_pkg::OFF_FIFO)) begin
                fifo_ff <= i_bus.wdata[5:0];
            end
            if (!fifo_ovr) begin
                o_ep_size <= {ep_bytes(fifo_ff[5:4]), ep_bytes(fifo_ff[3:2]),
                              ep_bytes(fifo_ff[1:0])};
            end
        end
    end

    // ========================================
    // clock control
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lclk_ff <= 1'b0;
            deep_ff <= 1'b0;
        end else if (i_ce && hit(i_bus, usb_ctl_pkg::OFF_CLK)) begin
            lclk_ff <= i_bus.wdata[usb_ctl_pkg::B_LCLK];
            deep_ff <= i_bus.wdata[usb_ctl_pkg::B_DEEP];
        end
    end

    // ========================================
    // interrupt and registered outputs
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_ff        <= 1'b0;
            pins_ff       <= '0;
            o_pullup_en   <= 1'b0;
            o_pll_off     <= 1'b0;
            o_reg33_en    <= 1'b0;
            o_legacy_mode <= 1'b0;
            o_link_clk_en <= 1'b0;
            o_deep_idle   <= 1'b0;
        end else if (i_ce) begin
            irq_ff        <= bus_idle_flag_set || resume_set || brst_set ||
                             ep_irq;
            pins_ff       <= nxt_pins;
            o_pullup_en   <= pullup_ff;
            o_pll_off     <= bus_ctl_ff[usb_ctl_pkg::B_PLLOFF];
            o_reg33_en    <= bus_ctl_ff[usb_ctl_pkg::B_REG33];
            o_legacy_mode <= bus_ctl_ff[usb_ctl_pkg::B_LEGACY];
            o_link_clk_en <= lclk_ff;
            o_deep_idle   <= deep_ff;
        end
    end

    // ========================================
    // read port, data one cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_ff <= 8'h00;
        end else if (i_ce) begin
            rdata_ff <= 8'h00;
            if (i_bus.rd) begin
                case (i_bus.addr)
                    usb_ctl_pkg::OFF_LINE:
                        rdata_ff <= {2'b00, dp_sync_ff[1], dm_sync_ff[1],
                                     se1_ff, se0_ff, pullup_ff, 1'b0};
                    usb_ctl_pkg::OFF_EPEN:
                        rdata_ff <= {4'h0, ep_en_ff};
                    usb_ctl_pkg::OFF_BUS:
                        rdata_ff <= {bus_ctl_ff[7:4], resume_ff, brst_ff,
                                     wake_ff,
                                     state_ff != usb_ctl_pkg::LINK_ACTIVE};
                    usb_ctl_pkg::OFF_EPREQ:
                        rdata_ff <= {4'h0, ep_req_ff};
                    usb_ctl_pkg::OFF_CLK:
                        rdata_ff <= {3'b000, deep_ff, lclk_ff, 3'b000};
                    usb_ctl_pkg::OFF_FIFO:
                        rdata_ff <= {fifo_ovr, 1'b0, fifo_ff};
                    default: rdata_ff <= 8'h00;
                endcase
            end
        end
    end

    assign o_rdata     = rdata_ff;
    assign o_usb_irq   = irq_ff;
    assign o_cpu_reset = cpu_rst_ff;
    assign o_pins      = pins_ff;

    // ========================================
    // assertions
    a_suspend_irq: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && bus_idle_flag_set |=> o_usb_irq && state_ff == usb_ctl_pkg::LINK_BUS_IDLE_FLAG)
        else $error("suspend entry without interrupt");
    a_suspend_cause: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(state_ff == usb_ctl_pkg::LINK_BUS_IDLE_FLAG) &&
        $past(state_ff) == usb_ctl_pkg::LINK_ACTIVE |->
        $past(idle_done) && $past(clk_run))
        else $error("suspend entered before bus silence timeout");
    a_resume_flag: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && resume_set |=> resume_ff && o_usb_irq)
        else $error("resume not flagged");
    a_resume_clear: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        state_ff == usb_ctl_pkg::LINK_ACTIVE |-> !resume_ff)
        else $error("resume flag left set while bus active");
    a_wake_drive: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && !wake_ff && wr_bus && i_bus.wdata[usb_ctl_pkg::B_WAKE]
        ##1 i_ce |=> o_pins.dp_oe && o_pins.dm_oe && !o_pins.dp_out)
        else $error("wake request did not drive the lines");
    a_reset_prop: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && brst_set |=> brst_ff &&
        o_cpu_reset == $past(bus_ctl_ff[usb_ctl_pkg::B_RSTPROP]))
        else $error("bus reset propagation wrong");
    a_noise_hold: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        se0_ff && !wr_line |=> se0_ff)
        else $error("se0 noise flag lost without firmware clear");
    a_ep_gate: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && !bus_idle_flag_set && !resume_set && !brst_set &&
        (i_stack_full || !i_usb_irq_en) |=> !o_usb_irq)
        else $error("endpoint interrupt despite full stack or mask");
    a_set_wins: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && wr_epreq && ep_set[0] |=> ep_req_ff[0])
        else $error("endpoint flag clear beat a new access");
    a_read_enable: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && i_bus.rd && i_bus.addr == usb_ctl_pkg::OFF_EPEN |=>
        o_rdata == {4'h0, $past(ep_en_ff)})
        else $error("enable register read back wrong");

endmodule

// file: rtl/usb_ctl_pkg.sv
// constants, register map and carriers for the usb status and power block
// assumes a 125 MHz clock and an 8-bit firmware register port
package usb_ctl_pkg;

    // ========================================
    // register offsets
    localparam logic [2:0] OFF_LINE  = 3'h0;
    localparam logic [2:0] OFF_EPEN  = 3'h1;
    localparam logic [2:0] OFF_BUS   = 3'h2;
    localparam logic [2:0] OFF_EPREQ = 3'h3;
    localparam logic [2:0] OFF_CLK   = 3'h4;
    localparam logic [2:0] OFF_FIFO  = 3'h5;

    // ========================================
    // field positions
    localparam int B_PULLUP   = 1;
    localparam int B_SE0      = 2;
    localparam int B_SE1      = 3;
    localparam int B_DM_IN    = 4;
    localparam int B_DP_IN    = 5;
    localparam int B_DM_DRV   = 6;
    localparam int B_DP_DRV   = 7;
    localparam int B_IDLE     = 0;
    localparam int B_WAKE     = 1;
    localparam int B_BRST     = 2;
    localparam int B_RESUME   = 3;
    localparam int B_REG33    = 4;
    localparam int B_PLLOFF   = 5;
    localparam int B_LEGACY   = 6;
    localparam int B_RSTPROP  = 7;
    localparam int B_LCLK     = 3;
    localparam int B_DEEP     = 4;
    localparam int B_FIFO_OVR = 7;

    // ========================================
    // reset values and sizes
    localparam logic [7:0] BUS_RESET  = 8'h80;
    localparam logic [5:0] FIFO_RESET = 6'h00;
    localparam int         NUM_EP     = 4;
    localparam logic [7:0] EP0_BYTES  = 8'h08;
    localparam logic [7:0] EPX_BUDGET = 8'h40;
    localparam logic [7:0] EPX_MIN    = 8'h08;

    // ========================================
    // timing
    localparam int CLK_KHZ      = 125000;
    localparam int IDLE_TIME_MS = 3;
    localparam int WAKE_TIME_MS = 2;
    localparam int IDLE_CYCLES  = IDLE_TIME_MS * CLK_KHZ;
    localparam int WAKE_CYCLES  = WAKE_TIME_MS * CLK_KHZ;
    localparam int CNT_W        = 20;

    typedef enum logic [1:0] {
        LINK_ACTIVE = 2'b00,
        LINK_BUS_IDLE_FLAG   = 2'b01,
        LINK_RESUME = 2'b10
    } link_state_e;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    typedef struct packed {
        logic dp_out;
        logic dp_oe;
        logic dm_out;
        logic dm_oe;
    } pin_drive_s;

endpackage

// file: verification/usb_host_model.sv
// host side model: bus activity, resume, bus reset, noise, line levels
// assumes the device pin drive struct of the package
`timescale 1ns/100ps
module usb_host_model (
    // clock and requests
    input  wire logic                    i_clk,
    input  wire logic                    i_act,
    input  wire logic [3:0]              i_req,
    input  wire usb_ctl_pkg::pin_drive_s i_pins,
    // bus events and line levels
    output logic                         o_act = 1'b0,
    output logic                         o_resume = 1'b0,
    output logic                         o_reset,
    output logic                         o_se0 = 1'b0,
    output logic                         o_se1 = 1'b0,
    output logic                         o_dp,
    output logic                         o_dm
);
    logic       k_ff = 1'b0;
    logic [2:0] rst_ff = 3'h0;
    wire        k = i_pins.dp_oe & !i_pins.dp_out &
                    i_pins.dm_oe & i_pins.dm_out;
    always @(posedge i_clk) begin
        k_ff     <= k;
        o_act    <= i_act;
        o_resume <= i_req[0] | (k_ff & !k);
        rst_ff   <= i_req[1] ? 3'h4 : rst_ff - 3'(|rst_ff);
        o_se0    <= i_req[2];
        o_se1    <= i_req[3];
    end
    assign o_reset = |rst_ff;
    // released lines sit at idle: pull-up on d+, pull-down on d-
    assign o_dp = i_pins.dp_oe ? i_pins.dp_out : 1'b1;
    assign o_dm = i_pins.dm_oe ? i_pins.dm_out : 1'b0;
endmodule

// file: verification/usb_device_status_and_power_control_test.sv
// self-checking bench for the usb status and power block
// assumes the host model on the bus side and short idle and wake counts
`timescale 1ns/100ps
module usb_device_status_and_power_control_test;
    localparam int IDLE = 20;
    localparam int WAKE = 10;
    logic                    i_clk = 1'b0;
    logic                    i_rstn = 1'b0;
    usb_ctl_pkg::bus_req_s   bus = '0;
    logic [3:0]              ep_hit = '0;
    logic [3:0]              req = '0;
    logic                    act = 1'b1;
    logic                    irq_en = 1'b0;
    logic                    stk_full = 1'b0;
    usb_ctl_pkg::pin_drive_s pins;
    logic [7:0]              rdata;
    logic [23:0]             ep_size;
    logic                    irq, cpu_rst, act_w, res_w, rst_w, se0, se1;
    logic                    dp, dm, pull, pll, r33, leg, lclk, deep;
    int                      fail_count = 0;
    int                      n_checks = 0;
    int                      irq_n = 0;
    int                      cpu_n = 0;

    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        irq_n <= irq_n + int'(irq === 1'b1);
        cpu_n <= cpu_n + int'(cpu_rst === 1'b1);
    end

    usb_status_power #(.IDLE_CYC(IDLE), .WAKE_CYC(WAKE)) dut_u (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_bus(bus),
        .o_rdata(rdata), .i_bus_active(act_w), .i_resume_det(res_w),
        .i_reset_det(rst_w), .i_se0_noise(se0), .i_se1_noise(se1),
        .i_ep_hit(ep_hit), .i_usb_irq_en(irq_en), .i_stack_full(stk_full),
        .o_usb_irq(irq), .o_cpu_reset(cpu_rst), .i_dp_pin(dp),
        .i_dm_pin(dm), .o_pins(pins), .o_pullup_en(pull), .o_pll_off(pll),
        .o_reg33_en(r33), .o_legacy_mode(leg), .o_link_clk_en(lclk),
        .o_deep_idle(deep), .o_ep_size(ep_size));
    usb_host_model host_u (
        .i_clk(i_clk), .i_act(act), .i_req(req), .i_pins(pins),
        .o_act(act_w), .o_resume(res_w), .o_reset(rst_w), .o_se0(se0),
        .o_se1(se1), .o_dp(dp), .o_dm(dm));

    // ========================================
    // shared tasks
    task automatic chk(string nm, logic [23:0] s, logic [23:0] e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] v);
        @(posedge i_clk);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge i_clk);
        bus <= '0;
    endtask
    task automatic rd(logic [2:0] a, logic [7:0] e);
        @(posedge i_clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_clk);
        bus <= '0;
        #1 chk($sformatf("reg%0d", a), 24'(rdata), 24'(e));
    endtask
    task automatic pulse(logic [3:0] e, logic [3:0] r);
        @(posedge i_clk);
        ep_hit <= e;
        req <= r;
        @(posedge i_clk);
        ep_hit <= '0;
        req <= '0;
    endtask
    task automatic st;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge i_clk);
        fail_count++;
        results();
    end

    // ========================================
    // scenarios
    initial begin
        int v, ep, n0, c0;
        v = $urandom(32'h978c_ab37);
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk("ep_size", ep_size, 24'h08_0808);
        rd(3'h0, 8'h20);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h80);
        rd(3'h3, 8'h00);
        rd(3'h6, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            wr(3'h2, {1'b1, v[2:0], 4'h0});
            wr(3'h0, {6'h30, v[3], 1'b0});
            st();
            chk("reg33", 24'(r33), 24'(v[0]));
            chk("pll", 24'(pll), 24'(v[1]));
            chk("legacy", 24'(leg), 24'(v[2]));
            chk("pullup", 24'(pull), 24'(v[3]));
        end
        wr(3'h2, 8'hc0);
        wr(3'h0, 8'h42);
        st();
        chk("ps2_pins", 24'(pins), 24'h00_0004);
        rd(3'h0, 8'h02);
        wr(3'h0, 8'hc0);
        wr(3'h2, 8'h80);
        wr(3'h4, 8'h08);
        st();
        chk("link_clk", 24'(lclk), 24'h00_0001);
        // ep1 32, ep2 16, ep3 8 bytes fits the budget
        wr(3'h5, 8'h06);
        st();
        chk("ep_size", ep_size, 24'h08_1020);
        // all 64 bytes overflows, sizes keep their last value
        wr(3'h5, 8'h3f);
        st();
        chk("ep_size", ep_size, 24'h08_1020);
        rd(3'h5, 8'hbf);
        wr(3'h5, 8'h00);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'h0000_004f : $urandom;
            ep = int'(v[5:4]);
            wr(3'h1, {4'h0, v[3:0]});
            irq_en <= v[6];
            stk_full <= v[7] & v[8];
            n0 = irq_n;
            pulse(4'(1 << ep), 4'h0);
            st();
            chk("ep_irq", 24'(irq_n - n0), 24'(v[ep] & v[6] & !(v[7] & v[8])));
            rd(3'h3, 8'(1 << ep));
            wr(3'h3, 8'h00);
        end
        @(posedge i_clk);
        bus <= '{3'h3, 8'h00, 1'b1, 1'b0};
        ep_hit <= 4'h2;
        @(posedge i_clk);
        bus <= '0;
        ep_hit <= 4'h0;
        rd(3'h3, 8'h02);
        wr(3'h3, 8'h00);
        for (int b = 2; b < 4; b++) begin
            pulse(4'h0, 4'(1 << b));
            rd(3'h0, 8'h20 | 8'(1 << b));
            wr(3'h0, 8'hc0 | 8'(1 << b));
            rd(3'h0, 8'h20 | 8'(1 << b));
            wr(3'h0, 8'hc0);
            rd(3'h0, 8'h20);
        end
        for (int i = 0; i < 2; i++) begin
            wr(3'h2, {i[0], 7'h00});
            n0 = irq_n;
            c0 = cpu_n;
            pulse(4'h0, 4'h2);
            repeat (8) @(posedge i_clk);
            chk("rst_irq", 24'(irq_n - n0), 24'h00_0001);
            chk("cpu_rst", 24'(cpu_n - c0), 24'(i));
            rd(3'h2, {i[0], 7'h04});
        end
        wr(3'h2, 8'h80);
        act <= 1'b0;
        n0 = irq_n;
        repeat (IDLE + 10) @(posedge i_clk);
        chk("idle_irq", 24'(irq_n - n0), 24'h00_0001);
        wr(3'h2, 8'h80);
        rd(3'h2, 8'h81);
        // firmware parks the clock and cuts power while suspended
        wr(3'h4, 8'h10);
        st();
        chk("link_clk", 24'(lclk), 24'h00_0000);
        chk("deep_idle", 24'(deep), 24'h00_0001);
        n0 = irq_n;
        wr(3'h2, 8'h82);
        repeat (3) @(posedge i_clk);
        chk("wake_k", 24'(pins), 24'h00_0007);
        repeat (WAKE + 10) @(posedge i_clk);
        chk("res_irq", 24'(irq_n - n0), 24'h00_0001);
        rd(3'h2, 8'h89);
        wr(3'h4, 8'h08);
        st();
        chk("deep_idle", 24'(deep), 24'h00_0000);
        chk("link_clk", 24'(lclk), 24'h00_0001);
        act <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd(3'h2, 8'h80);
        results();
    end
endmodule
